// ### core/dpdiag_pkg.sv
/*
  constants for the slave diagnostic frame builder: register map,
  field positions, frame layout, section codes.
  assumes a 32-bit word-aligned register bus with byte addresses.
*/
package dpdiag_pkg;
  // =====================================================
  // register map (byte addresses)
  localparam logic [8:0] CTRL_OFF = 9'h000;
  localparam logic [8:0] ENABLE_OFF = 9'h004;
  localparam logic [8:0] COUNT_OFF = 9'h008;
  localparam logic [8:0] STATUS_OFF = 9'h00c;
  localparam logic [8:0] PACK_OFF = 9'h010;
  localparam logic [8:0] SLOT_OFF = 9'h020;
  localparam logic [8:0] SUBM_OFF = 9'h030;
  localparam logic [8:0] DEV_OFF = 9'h040;
  localparam logic [8:0] CHAN_OFF = 9'h100;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  // =====================================================
  // control, enable, count and status word fields
  localparam int CTRL_PERR = 5;
  localparam int CTRL_REPARAM = 6;
  localparam int CTRL_WDOG = 7;
  localparam int CTRL_FREEZE = 8;
  localparam int CTRL_SYNC = 9;
  localparam int CTRL_PDONE = 10;
  localparam int CTRL_ADDR_LSB = 16;
  localparam int EN_IDENT = 4;
  localparam int EN_SUBM = 5;
  localparam int EN_CHAN = 6;
  localparam int COUNT_DEV_LSB = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_PERR = 1;
  localparam int ST_OVF = 2;
  localparam int ST_OFS_LSB = 4;
  localparam int ST_USED_LSB = 16;
  // =====================================================
  // device block kinds, submodule states, packing widths
  localparam logic [1:0] DEV_NONE = 2'h0;
  localparam logic [1:0] DEV_DIAG = 2'h1;
  localparam logic [1:0] DEV_PROC = 2'h2;
  localparam logic [1:0] SM_OK = 2'h0;
  localparam logic [1:0] SM_ERR = 2'h1;
  localparam logic [1:0] SM_WRONG = 2'h2;
  localparam logic [1:0] SM_MISSING = 2'h3;
  localparam logic [1:0] W_NONE = 2'h0;
  localparam logic [1:0] W_2 = 2'h1;
  localparam logic [1:0] W_4 = 2'h2;
  localparam logic [4:0] PACK_BITS = 5'h08;
  // =====================================================
  // frame layout
  localparam logic [4:0] BASIC_LEN = 5'h06;
  localparam logic [4:0] IDENT_LEN = 5'h09;
  localparam logic [4:0] SUBM_LEN = 5'h14;
  localparam logic [4:0] CHAN_LEN = 5'h03;
  localparam logic [4:0] DEV_DIAG_LEN = 5'h0c;
  localparam logic [4:0] DEV_PROC_LEN = 5'h08;
  localparam logic [6:0] CHAN_MAX = 7'h40;
  localparam logic [7:0] IDENT_HDR = 8'h49;
  localparam logic [7:0] SUBM_HDR = 8'h14;
  localparam logic [7:0] SUBM_TYPE = 8'h82;
  localparam logic [7:0] ADDR_UNSET = 8'hff;
  localparam logic [9:0] POS_IDENT = 10'h006;
  localparam logic [9:0] POS_SUBM = 10'h00f;
  localparam logic [9:0] POS_CHAN = 10'h023;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_BASIC = 3'b001, S_IDENT = 3'b011, S_SUBM = 3'b010,
    S_FETCH = 3'b110, S_CHAN = 3'b111, S_DEV = 3'b101
  } sec_type;
endpackage : dpdiag_pkg

// ### core/chan_mem.sv
/*
  channel entry store: one write port, one read port, read data registered.
  assumes both ports on the same clock; no reset on contents.
*/
`timescale 1ns/1ps
module chan_mem #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 24,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem_r[rd_addr];
  end
endmodule : chan_mem

// ### core/dp_diag_frame.sv
/*
  diagnostic frame builder with avalon-mm register slave and packing checker.
  assumes FRAME_REQ and FRAME_READY come from logic on CLK; one clock domain.
*/
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
// Function
// - first packed module starts at bit 0; later ones take next free bits
// - packing allowed only for digital modules of 2 or 4 bits
// - packed group needing more than eight bits flags parameter error
// - partly filled packed byte accepted; unused bits carry no data
// - frame opens with six status bytes, then only enabled blocks
// - submodule status block is twenty bytes at frame bytes 15 to 34
// - channel entries start at byte 35, zero to 64 of three bytes
// - at most one closing device block: twelve or eight bytes
// - status byte 0 flags; bits 5 and 7 zero
// - status byte 1 flags, bit 2 one; bits 1, 6, 7 zero
// - status byte 2 zero except overflow bit 7
// - byte 3 all ones until parameterized, then master address
// - bytes 4 and 5 carry fixed manufacturer code
// - one error bit per slot 1..64 at byte 7+(n-1)/8
// - identifier block at byte 6, nine bytes, header code 01 length 9
// - identifier block presence set by a master parameter
// - parameter byte 6 bits 4,5,6 enable the optional blocks
// - slot state 00 ok, 01 error, 10 wrong type, 11 missing
`timescale 1ns/1ps
module dp_diag_frame #(
  parameter logic [15:0] MFR_ID = 16'h1234 // arbitrary value
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [8:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  input wire logic FRAME_REQ,
  input wire logic FRAME_READY,
  output logic [7:0] FRAME_DATA,
  output logic FRAME_VALID,
  output logic FRAME_LAST
);
  // =====================================================
  // bus slave
  logic wait_r;
  logic wr_acc;
  logic [31:0] ctrl_r, pack_r, rd_mux;
  logic [7:0] en_r;
  logic [6:0] count_r, nch;
  logic [1:0] devtype_r;
  logic [63:0] slot_r, ident_bits;
  logic [127:0] subm_r;
  logic [95:0] dev_r;
  logic pack_err_r, ovf;
  logic [11:0] ofs_r;
  logic [7:0] used_r;
  dpdiag_pkg::sec_type sec_r, sec_nxt, out_sec_r;
  logic [4:0] idx_r, idx_nxt, im1, im4;
  logic [5:0] ent_r, ent_nxt;
  logic last_nxt, load;
  logic [7:0] cur_byte;
  logic [23:0] ch_data;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      if (be[b]) old[8*b +: 8] = wd[8*b +: 8];
    end
    return old;
  endfunction : merge

  // waitrequest drops one cycle after a request appears
  always_ff @(posedge CLK) begin
    if (RESET) wait_r <= 1'b1;
    else if ((READ || WRITE) && wait_r) wait_r <= 1'b0;
    else wait_r <= 1'b1;
  end
  assign WAITREQUEST = wait_r;
  assign wr_acc = WRITE && !wait_r;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl_r <= dpdiag_pkg::REG_RST;
      en_r <= dpdiag_pkg::REG_RST[7:0];
      count_r <= dpdiag_pkg::REG_RST[6:0];
      devtype_r <= dpdiag_pkg::DEV_NONE;
      pack_r <= dpdiag_pkg::REG_RST;
    end else if (wr_acc) begin
      if (ADDRESS[8:2] == dpdiag_pkg::CTRL_OFF[8:2]) begin
        ctrl_r <= merge(ctrl_r, WRITEDATA, BYTEENABLE);
      end
      if (ADDRESS[8:2] == dpdiag_pkg::ENABLE_OFF[8:2] && BYTEENABLE[0]) begin
        en_r <= WRITEDATA[7:0];
      end
      if (ADDRESS[8:2] == dpdiag_pkg::COUNT_OFF[8:2]) begin
        if (BYTEENABLE[0]) count_r <= WRITEDATA[6:0];
        if (BYTEENABLE[1]) devtype_r <= WRITEDATA[dpdiag_pkg::COUNT_DEV_LSB +: 2];
      end
      if (ADDRESS[8:2] == dpdiag_pkg::PACK_OFF[8:2]) begin
        pack_r <= merge(pack_r, WRITEDATA, BYTEENABLE);
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      slot_r <= '0;
      subm_r <= '0;
      dev_r <= '0;
    end else if (wr_acc) begin
      if (ADDRESS[8:3] == dpdiag_pkg::SLOT_OFF[8:3]) begin
        slot_r[{ADDRESS[2], 5'h00} +: 32] <=
          merge(slot_r[{ADDRESS[2], 5'h00} +: 32], WRITEDATA, BYTEENABLE);
      end
      if (ADDRESS[8:4] == dpdiag_pkg::SUBM_OFF[8:4]) begin
        subm_r[{ADDRESS[3:2], 5'h00} +: 32] <=
          merge(subm_r[{ADDRESS[3:2], 5'h00} +: 32], WRITEDATA, BYTEENABLE);
      end
      if (ADDRESS[8:4] == dpdiag_pkg::DEV_OFF[8:4] && ADDRESS[3:2] != 2'h3) begin
        dev_r[{ADDRESS[3:2], 5'h00} +: 32] <=
          merge(dev_r[{ADDRESS[3:2], 5'h00} +: 32], WRITEDATA, BYTEENABLE);
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (ADDRESS[8:2])
      dpdiag_pkg::CTRL_OFF[8:2]: rd_mux = ctrl_r;
      dpdiag_pkg::ENABLE_OFF[8:2]: rd_mux = {24'h000000, en_r};
      dpdiag_pkg::COUNT_OFF[8:2]: rd_mux = {22'h000000, devtype_r, 1'b0, count_r};
      dpdiag_pkg::STATUS_OFF[8:2]: rd_mux = {8'h00, used_r, ofs_r, 1'b0, ovf, pack_err_r,
                                             sec_r != dpdiag_pkg::S_IDLE};
      dpdiag_pkg::PACK_OFF[8:2]: rd_mux = pack_r;
      dpdiag_pkg::SLOT_OFF[8:2]: rd_mux = slot_r[31:0];
      dpdiag_pkg::SLOT_OFF[8:2] + 7'h01: rd_mux = slot_r[63:32];
      default: rd_mux = 32'h0000_0000; // unmapped and channel store read zero
    endcase
  end

  // read data captured while waitrequest is still high
  always_ff @(posedge CLK) begin
    if (RESET) READDATA <= 32'h0000_0000;
    else if (READ && wait_r) READDATA <= rd_mux;
  end

  // =====================================================
  // packing checker
  always_ff @(posedge CLK) begin
    logic [4:0] sum;
    logic [4:0] w;
    logic bad;
    logic dir0;
    logic seen;
    logic [15:0] mask;
    sum = 5'h00;
    bad = 1'b0;
    dir0 = 1'b0;
    seen = 1'b0;
    mask = 16'h0000;
    if (RESET) begin
      pack_err_r <= 1'b0;
      ofs_r <= 12'h000;
      used_r <= 8'h00;
    end else begin
      for (int k = 0; k < 4; k++) begin
        w = (pack_r[4*k +: 2] == dpdiag_pkg::W_2) ? 5'h02 :
            (pack_r[4*k +: 2] == dpdiag_pkg::W_4) ? 5'h04 : 5'h00;
        if (pack_r[4*k +: 2] != dpdiag_pkg::W_NONE) begin
          if (w == 5'h00 || !pack_r[4*k+3]) bad = 1'b1;
          if (seen && pack_r[4*k+2] != dir0) bad = 1'b1;
          if (!seen) dir0 = pack_r[4*k+2];
          seen = 1'b1;
          mask = mask | (((16'h0001 << w) - 16'h0001) << sum);
        end
        ofs_r[3*k +: 3] <= sum[2:0];
        sum = sum + w;
      end
      pack_err_r <= bad || (sum > dpdiag_pkg::PACK_BITS);
      used_r <= mask[7:0];
    end
  end

  // =====================================================
  // frame source data
  assign nch = (count_r > dpdiag_pkg::CHAN_MAX) ? dpdiag_pkg::CHAN_MAX : count_r;
  assign ovf = count_r > dpdiag_pkg::CHAN_MAX;
  assign im1 = idx_r - 5'h01;
  assign im4 = idx_r - 5'h04;

  always_comb begin
    for (int n = 0; n < 64; n++) begin
      ident_bits[n] = slot_r[n] || (subm_r[2*n +: 2] == dpdiag_pkg::SM_ERR);
    end
  end

  chan_mem #(.DEPTH(64), .WIDTH(24), .AW(6)) u_chan (
    .clk(CLK),
    .wr_en(wr_acc && ADDRESS[8]),
    .wr_addr(ADDRESS[7:2]),
    .wr_data(WRITEDATA[23:0]),
    .rd_addr(ent_r),
    .rd_data(ch_data)
  );

  function automatic logic [4:0] sec_len(input dpdiag_pkg::sec_type s, input logic [1:0] dt);
    case (s)
      dpdiag_pkg::S_BASIC: return dpdiag_pkg::BASIC_LEN;
      dpdiag_pkg::S_IDENT: return dpdiag_pkg::IDENT_LEN;
      dpdiag_pkg::S_SUBM: return dpdiag_pkg::SUBM_LEN;
      dpdiag_pkg::S_CHAN: return dpdiag_pkg::CHAN_LEN;
      dpdiag_pkg::S_DEV: return (dt == dpdiag_pkg::DEV_DIAG) ? dpdiag_pkg::DEV_DIAG_LEN :
                                dpdiag_pkg::DEV_PROC_LEN;
      default: return 5'h01;
    endcase
  endfunction : sec_len

  // disabled blocks are skipped so the next enabled one follows directly
  function automatic dpdiag_pkg::sec_type after(input dpdiag_pkg::sec_type s);
    after = dpdiag_pkg::S_IDLE;
    if (s == dpdiag_pkg::S_BASIC && en_r[dpdiag_pkg::EN_IDENT]) after = dpdiag_pkg::S_IDENT;
    else if ((s == dpdiag_pkg::S_BASIC || s == dpdiag_pkg::S_IDENT) &&
             en_r[dpdiag_pkg::EN_SUBM]) after = dpdiag_pkg::S_SUBM;
    else if ((s == dpdiag_pkg::S_BASIC || s == dpdiag_pkg::S_IDENT ||
              s == dpdiag_pkg::S_SUBM) && en_r[dpdiag_pkg::EN_CHAN] && nch != 7'h00) begin
      after = dpdiag_pkg::S_FETCH;
    end
    else if (s != dpdiag_pkg::S_DEV && devtype_r != dpdiag_pkg::DEV_NONE) begin
      after = dpdiag_pkg::S_DEV;
    end
  endfunction : after

  always_comb begin
    cur_byte = 8'h00;
    case (sec_r)
      dpdiag_pkg::S_BASIC: begin
        case (idx_r)
          5'h00: cur_byte = {1'b0, ctrl_r[dpdiag_pkg::CTRL_PERR] || pack_err_r, 1'b0,
                             ctrl_r[4:0]};
          5'h01: cur_byte = {2'b00, ctrl_r[dpdiag_pkg::CTRL_SYNC],
                             ctrl_r[dpdiag_pkg::CTRL_FREEZE], ctrl_r[dpdiag_pkg::CTRL_WDOG],
                             1'b1, 1'b0, ctrl_r[dpdiag_pkg::CTRL_REPARAM]};
          5'h02: cur_byte = {ovf, 7'h00};
          5'h03: cur_byte = ctrl_r[dpdiag_pkg::CTRL_PDONE] ?
                            ctrl_r[dpdiag_pkg::CTRL_ADDR_LSB +: 8] :
                            dpdiag_pkg::ADDR_UNSET;
          5'h04: cur_byte = MFR_ID[15:8];
          default: cur_byte = MFR_ID[7:0];
        endcase
      end
      dpdiag_pkg::S_IDENT: cur_byte = (idx_r == 5'h00) ? dpdiag_pkg::IDENT_HDR :
                                      ident_bits[{im1[2:0], 3'b000} +: 8];
      dpdiag_pkg::S_SUBM: begin
        case (idx_r)
          5'h00: cur_byte = dpdiag_pkg::SUBM_HDR;
          5'h01: cur_byte = dpdiag_pkg::SUBM_TYPE;
          5'h02, 5'h03: cur_byte = 8'h00;
          default: cur_byte = subm_r[{im4[3:0], 3'b000} +: 8];
        endcase
      end
      dpdiag_pkg::S_CHAN: begin
        case (idx_r)
          5'h00: cur_byte = ch_data[23:16];
          5'h01: cur_byte = ch_data[15:8];
          default: cur_byte = ch_data[7:0];
        endcase
      end
      dpdiag_pkg::S_DEV: cur_byte = dev_r[{idx_r[3:0], 3'b000} +: 8];
      default: cur_byte = 8'h00;
    endcase
  end

  // =====================================================
  // frame sequencer
  assign load = (sec_r != dpdiag_pkg::S_IDLE) && (sec_r != dpdiag_pkg::S_FETCH) &&
                (!FRAME_VALID || FRAME_READY);

  always_comb begin
    sec_nxt = sec_r;
    idx_nxt = idx_r;
    ent_nxt = ent_r;
    last_nxt = 1'b0;
    case (sec_r)
      dpdiag_pkg::S_IDLE: begin
        if (FRAME_REQ) begin
          sec_nxt = dpdiag_pkg::S_BASIC;
          idx_nxt = 5'h00;
          ent_nxt = 6'h00;
        end
      end
      dpdiag_pkg::S_FETCH: sec_nxt = dpdiag_pkg::S_CHAN; // store read settles here
      dpdiag_pkg::S_BASIC, dpdiag_pkg::S_IDENT, dpdiag_pkg::S_SUBM,
      dpdiag_pkg::S_CHAN, dpdiag_pkg::S_DEV: begin
        if (load) begin
          idx_nxt = idx_r + 5'h01;
          if (idx_r == sec_len(sec_r, devtype_r) - 5'h01) begin
            idx_nxt = 5'h00;
            if (sec_r == dpdiag_pkg::S_CHAN && {1'b0, ent_r} != nch - 7'h01) begin
              ent_nxt = ent_r + 6'h01;
              sec_nxt = dpdiag_pkg::S_FETCH;
            end else begin
              sec_nxt = after(sec_r);
              last_nxt = (sec_nxt == dpdiag_pkg::S_IDLE);
            end
          end
        end
      end
      default: sec_nxt = dpdiag_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      sec_r <= dpdiag_pkg::S_IDLE;
      idx_r <= 5'h00;
      ent_r <= 6'h00;
    end else begin
      sec_r <= sec_nxt;
      idx_r <= idx_nxt;
      ent_r <= ent_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      FRAME_DATA <= 8'h00;
      FRAME_VALID <= 1'b0;
      FRAME_LAST <= 1'b0;
      out_sec_r <= dpdiag_pkg::S_IDLE;
    end else if (load) begin
      FRAME_DATA <= cur_byte;
      FRAME_VALID <= 1'b1;
      FRAME_LAST <= last_nxt;
      out_sec_r <= sec_r;
    end else if (FRAME_READY) begin
      FRAME_VALID <= 1'b0;
      FRAME_LAST <= 1'b0;
    end
  end

  // =====================================================
  // checks
  logic [9:0] pos_r;
  always_ff @(posedge CLK) begin
    if (RESET) pos_r <= 10'h000;
    else if (FRAME_VALID && FRAME_READY) pos_r <= FRAME_LAST ? 10'h000 : pos_r + 10'h001;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_start;
    sec_r == dpdiag_pkg::S_IDLE && FRAME_REQ;
  endsequence
  sequence s_pack_wr;
    wr_acc && ADDRESS[8:2] == dpdiag_pkg::PACK_OFF[8:2];
  endsequence

  a_frame_opens: assert property (s_start |=>
    sec_r == dpdiag_pkg::S_BASIC && idx_r == 5'h00)
    else $error("frame did not open with status bytes");
  a_status0_zero: assert property (FRAME_VALID && pos_r == 10'h000 |->
    !FRAME_DATA[5] && !FRAME_DATA[7])
    else $error("status byte 0 reserved bits set");
  a_status1_fixed: assert property (FRAME_VALID && pos_r == 10'h001 |->
    FRAME_DATA[2] && !FRAME_DATA[1] && FRAME_DATA[7:6] == 2'b00)
    else $error("status byte 1 fixed bits wrong");
  a_status2_zero: assert property (FRAME_VALID && pos_r == 10'h002 |->
    FRAME_DATA[6:0] == 7'h00)
    else $error("status byte 2 low bits set");
  a_ident_header: assert property (FRAME_VALID && pos_r == dpdiag_pkg::POS_IDENT &&
    en_r[dpdiag_pkg::EN_IDENT] |-> FRAME_DATA == dpdiag_pkg::IDENT_HDR)
    else $error("identifier header wrong");
  a_subm_header: assert property (FRAME_VALID && pos_r == dpdiag_pkg::POS_SUBM &&
    en_r[5:4] == 2'b11 |-> FRAME_DATA == dpdiag_pkg::SUBM_HDR)
    else $error("submodule header not at byte 15");
  a_skip_ident: assert property (FRAME_VALID && pos_r == dpdiag_pkg::POS_IDENT &&
    en_r[5:4] == 2'b10 |-> FRAME_DATA == dpdiag_pkg::SUBM_HDR)
    else $error("disabled block not omitted");
  a_chan_start: assert property (FRAME_VALID && pos_r == dpdiag_pkg::POS_CHAN &&
    en_r[6:4] == 3'b111 && nch != 7'h00 |-> out_sec_r == dpdiag_pkg::S_CHAN)
    else $error("channel entries not at byte 35");
  a_dev_length: assert property (FRAME_VALID && FRAME_LAST && en_r[6:4] == 3'b000 &&
    devtype_r != dpdiag_pkg::DEV_NONE |->
    pos_r == ((devtype_r == dpdiag_pkg::DEV_DIAG) ? 10'h011 : 10'h00d))
    else $error("device block length wrong");
  a_pack_over: assert property (s_pack_wr ##1 (pack_r[1:0] == dpdiag_pkg::W_4 &&
    pack_r[5:4] == dpdiag_pkg::W_4 && pack_r[9:8] == dpdiag_pkg::W_2) |=> pack_err_r)
    else $error("overfull packed byte not flagged");
  a_pack_offset: assert property (pack_r[1:0] == dpdiag_pkg::W_2 &&
    pack_r[5:4] != dpdiag_pkg::W_NONE |=> ofs_r[2:0] == 3'h0 && ofs_r[5:3] == 3'h2)
    else $error("packed offsets wrong");
  a_pack_type: assert property (pack_r[1:0] != dpdiag_pkg::W_NONE && !pack_r[3] |=>
    pack_err_r)
    else $error("non-digital packed module accepted");
endmodule : dp_diag_frame

// ### verification/diag_master_model.sv
/*
  master-side model: takes diagnostic frame bytes, promptly or slowly.
  assumes the builder's valid/ready byte stream on the same clock.
*/
`timescale 1ns/1ps
module diag_master_model (
  input wire logic clk,
  input wire logic clear,
  input wire logic slow,
  input wire logic [7:0] frame_data,
  input wire logic frame_valid,
  input wire logic frame_last,
  output logic frame_ready
);
  // =====================================================
  // capture of one frame
  logic [7:0] rx [0:255];
  logic [1:0] tick_r = 2'h0;
  logic got_last;
  int n_rx;
  // slow mode takes one byte in four, so the builder must hold its byte
  assign frame_ready = !slow || (tick_r == 2'h0);
  always_ff @(posedge clk) begin
    tick_r <= tick_r + 2'h1;
  end
  always_ff @(posedge clk) begin
    if (clear) begin
      n_rx <= 0;
      got_last <= 1'b0;
    end else if (frame_valid && frame_ready) begin
      rx[n_rx[7:0]] <= frame_data;
      n_rx <= n_rx + 1;
      got_last <= frame_last;
    end
  end
endmodule : diag_master_model

// ### verification/tb_top.sv
/*
  testbench for the diagnostic frame builder: register tasks, frame runs.
  assumes the master model is compiled before this file.
*/
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] MFR = 16'h5a3c; // arbitrary value
  logic CLK, RESET, READ, WRITE, FRAME_REQ, slow, clear;
  logic WAITREQUEST, FRAME_READY, FRAME_VALID, FRAME_LAST;
  logic [8:0] ADDRESS;
  logic [31:0] WRITEDATA, READDATA;
  logic [3:0] BYTEENABLE;
  logic [7:0] FRAME_DATA;
  int n_mismatch, n_compared;
  dp_diag_frame #(.MFR_ID(MFR)) dp_diag_frame_inst (.CLK(CLK), .RESET(RESET),
    .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
    .BYTEENABLE(BYTEENABLE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
    .FRAME_REQ(FRAME_REQ), .FRAME_READY(FRAME_READY), .FRAME_DATA(FRAME_DATA),
    .FRAME_VALID(FRAME_VALID), .FRAME_LAST(FRAME_LAST));
  diag_master_model diag_master_model_inst (.clk(CLK), .clear(clear), .slow(slow),
    .frame_data(FRAME_DATA), .frame_valid(FRAME_VALID), .frame_last(FRAME_LAST),
    .frame_ready(FRAME_READY));
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // =====================================================
  // common tasks
  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic fchk(input int k, input logic [7:0] e);
    chk({24'h0, diag_master_model_inst.rx[k]}, {24'h0, e});
  endtask : fchk
  // held until waitrequest is seen low; one idle edge after release
  task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int i;
    ADDRESS <= a;
    WRITEDATA <= d;
    WRITE <= w;
    READ <= !w;
    i = 0;
    do begin
      @(posedge CLK);
      i++;
    end while (WAITREQUEST !== 1'b0 && i < 50);
    if (WAITREQUEST !== 1'b0) begin
      n_mismatch++;
      test_done();
    end
    q = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
    @(posedge CLK);
  endtask : bus
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdchk(input logic [8:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask : rdchk
  task automatic run_frame(input logic s, input int len);
    int i;
    slow <= s;
    clear <= 1'b1;
    @(posedge CLK);
    clear <= 1'b0;
    FRAME_REQ <= 1'b1;
    @(posedge CLK);
    FRAME_REQ <= 1'b0;
    i = 0;
    do begin
      @(posedge CLK);
      i++;
    end while (diag_master_model_inst.got_last !== 1'b1 && i < 2000);
    if (diag_master_model_inst.got_last !== 1'b1) begin
      n_mismatch++;
      test_done();
    end
    chk(diag_master_model_inst.n_rx, len);
  endtask : run_frame
  // =====================================================
  // scenarios
  task automatic t_reset;
    chk({31'h0, WAITREQUEST}, 32'h1);
    chk({31'h0, FRAME_VALID}, 32'h0);
    rdchk(9'h000, 32'hffff_ffff, 32'h0);
    rdchk(9'h050, 32'hffff_ffff, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_basic;
    run_frame(1'b0, 6);
    fchk(0, 8'h00);
    fchk(1, 8'h04);
    fchk(2, 8'h00);
    fchk(3, 8'hff);
    fchk(4, MFR[15:8]);
    fchk(5, MFR[7:0]);
    $display("test basic done");
  endtask : t_basic
  task automatic t_pack;
    // inputs only, never mixed in one byte
    logic [15:0] pk [5] = '{16'h0a99, 16'h00aa, 16'h09aa, 16'h0002, 16'h000b};
    logic [31:0] mk [5] = '{32'h00ff_1ff2, 32'h00ff_03f2, 32'h2, 32'h2, 32'h2};
    logic [31:0] ex [5] = '{32'h00ff_1100, 32'h00ff_0200, 32'h2, 32'h2, 32'h2};
    for (int j = 0; j < 5; j++) begin
      wr(9'h010, {16'h0, pk[j]});
      rdchk(9'h00c, mk[j], ex[j]);
    end
    run_frame(1'b0, 6);
    fchk(0, 8'h40);
    wr(9'h010, 32'h0);
    $display("test pack done");
  endtask : t_pack
  task automatic t_flags;
    logic [31:0] cw [3] = '{32'h002a_07ff, 32'h0055_0555, 32'h00aa_02aa};
    logic [23:0] ex [3] = '{24'h5f3d2a, 24'h151555, 24'h4a2cff};
    for (int j = 0; j < 3; j++) begin
      wr(9'h000, cw[j]);
      run_frame(1'b0, 6);
      fchk(0, ex[j][23:16]);
      fchk(1, ex[j][15:8]);
      fchk(3, ex[j][7:0]);
    end
    wr(9'h000, 32'h0);
    $display("test flags done");
  endtask : t_flags
  task automatic t_full;
    logic [47:0] ch = 48'h8a4b11_bfc207;
    wr(9'h004, 32'h70);
    wr(9'h008, 32'h0000_0102);
    wr(9'h020, 32'h0000_0001);
    wr(9'h024, 32'h8000_0000);
    wr(9'h030, 32'h0000_00e4);
    wr(9'h100, 32'h008a_4b11);
    wr(9'h104, 32'h00bf_c207);
    wr(9'h040, 32'h0403_020c);
    wr(9'h044, 32'h0807_0605);
    wr(9'h048, 32'h0c0b_0a09);
    run_frame(1'b1, 53);
    fchk(6, 8'h49);
    fchk(7, 8'h03);
    for (int k = 8; k < 14; k++) fchk(k, 8'h00);
    fchk(14, 8'h80);
    fchk(15, 8'h14);
    fchk(16, 8'h82);
    fchk(19, 8'he4);
    fchk(34, 8'h00);
    for (int k = 0; k < 6; k++) fchk(35 + k, ch[47 - 8 * k -: 8]);
    for (int k = 0; k < 12; k++) fchk(41 + k, (k == 0) ? 8'h0c : 8'(k + 1));
    $display("test full done");
  endtask : t_full
  task automatic t_omit;
    wr(9'h004, 32'h50);
    wr(9'h008, 32'h0000_0241);
    run_frame(1'b0, 215);
    fchk(2, 8'h80);
    fchk(6, 8'h49);
    fchk(15, 8'h8a);
    fchk(207, 8'h0c);
    fchk(214, 8'h08);
    rdchk(9'h00c, 32'h0000_0007, 32'h0000_0004);
    // submodule block alone moves up to byte 6
    wr(9'h004, 32'h20);
    run_frame(1'b0, 34);
    fchk(6, 8'h14);
    fchk(26, 8'h0c);
    wr(9'h004, 32'h00);
    run_frame(1'b0, 14);
    fchk(6, 8'h0c);
    fchk(13, 8'h08);
    $display("test omit done");
  endtask : t_omit
  // =====================================================
  // main sequence and overall limit
  initial begin
    RESET = 1'b1;
    READ = 1'b0;
    WRITE = 1'b0;
    FRAME_REQ = 1'b0;
    ADDRESS = 9'h000;
    WRITEDATA = 32'h0;
    BYTEENABLE = 4'hf;
    slow = 1'b0;
    clear = 1'b1;
    n_mismatch = 0;
    n_compared = 0;
    repeat (10) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    t_reset();
    t_basic();
    t_pack();
    t_flags();
    t_full();
    t_omit();
    test_done();
  end
  initial begin
    repeat (100000) @(posedge CLK);
    n_mismatch++;
    test_done();
  end
endmodule : tb_top
